/* hw/pmc_pkg.sv */
// Contract
// - Core-halt stops core, peripherals keep running.
// - Sleep instruction with deep-sleep clear enters halt.
// - Halt from handler wakes on takeable interrupt.
// - Clock-stop gates core and peripheral clocks.
// - Only enabled sources wake from clock-stop.
// - Fast wake keeps slow clock source running.
// - Deep-sleep set, select clear: clock-stop mode.
// - Either sleep instruction enters clock-stop mode.
// - Fourteen enabled pin wakes exit deepest sleep.
// - Listed peripheral sources also exit deepest sleep.
// - One retention control per RAM block.
// - Asleep indicator high throughout deepest sleep.
// - Core held until core supplies valid.
// - Reset held while battery below reset threshold.
// - Low-battery flag set below warning threshold.
// - Enables for analog power and three regulators.
// - Drive supply switch selects battery or buck.
// - Each peripheral has its own clock gate.
// - Reduced-speed modes differ only in clock speed.
// - Deep-sleep set, select set: deepest sleep mode.
// - Deepest sleep held until enabled wake or reset.
package pmc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PIN_WAKES = 14;
    localparam int SRC_WAKES = 8;
    localparam int WAKE_W = PIN_WAKES + SRC_WAKES;
    localparam int REGULATORS = 3;
    localparam int RAM_BLOCKS_DEF = 8;
    localparam int PERIPHS_DEF = 16;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RETAIN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_REGULATOR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_GATE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    // Configuration register fields.
    localparam int CFG_W = 6;
    localparam int CFG_MODE_SEL = 0;
    localparam int CFG_LOW_SPEED = 1;
    localparam int CFG_FAST_WAKE = 2;
    localparam int CFG_FAST_SRC_RTC = 3;
    localparam int CFG_DRV_BUCK = 4;
    localparam int CFG_ANALOG_EN = 5;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h20;

    // Status register fields.
    localparam int ST_MODE_LSB = 0;
    localparam int ST_MODE_W = 3;
    localparam int ST_LOW_BATT = 3;
    localparam int ST_RESET_HOLD = 4;
    localparam int ST_SUPPLY_OK = 5;

    // Mode codes shown in status.
    localparam logic [ST_MODE_W-1:0] CODE_POWERUP = 3'h0;
    localparam logic [ST_MODE_W-1:0] CODE_RUN = 3'h1;
    localparam logic [ST_MODE_W-1:0] CODE_HALT = 3'h2;
    localparam logic [ST_MODE_W-1:0] CODE_STOP = 3'h3;
    localparam logic [ST_MODE_W-1:0] CODE_DEEP = 3'h4;
    localparam logic [ST_MODE_W-1:0] CODE_RESTORE = 3'h5;

    localparam logic [REGULATORS-1:0] REG_RESET = 3'h7;

    typedef enum logic [2:0] {
        M_POWERUP, M_RUN, M_HALT, M_STOP, M_DEEP, M_RESTORE
    } mode_t;
endpackage

/* hw/wake_qualifier.sv */
`timescale 1ns/100ps
// Decides which pending events may end the current low-power mode.
module wake_qualifier
    import pmc_pkg::*;
(
    input wire logic [pmc_pkg::PIN_WAKES-1:0] pin_wake,
    input wire logic [pmc_pkg::SRC_WAKES-1:0] src_wake,
    input wire logic [pmc_pkg::WAKE_W-1:0] wake_en,
    input wire logic irq_pending,
    input wire logic irq_takeable,
    input wire logic slept_in_handler,
    output logic halt_wake,
    output logic enabled_wake
);
    // Inside a handler only an interrupt the core would take counts.
    always_comb begin
        halt_wake = slept_in_handler ? irq_takeable : irq_pending;
    end

    // Disabled sources are masked so that they cannot end a stop.
    always_comb begin
        enabled_wake = |({src_wake, pin_wake} & wake_en);
    end
endmodule // wake_qualifier

/* hw/power_mode_controller.sv */
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Power mode sequencer with a plain register port.
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int RAM_BLOCKS = pmc_pkg::RAM_BLOCKS_DEF,
    parameter int PERIPHS = pmc_pkg::PERIPHS_DEF
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [pmc_pkg::ADDR_W-1:0] ADDR,
    input wire logic [pmc_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [pmc_pkg::DATA_W-1:0] RDATA,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP_BIT,
    input wire logic IN_HANDLER,
    input wire logic IRQ_PENDING,
    input wire logic IRQ_TAKEABLE,
    input wire logic [pmc_pkg::PIN_WAKES-1:0] PIN_WAKE,
    input wire logic [pmc_pkg::SRC_WAKES-1:0] SRC_WAKE,
    input wire logic CORE_SUPPLY_VALID,
    input wire logic VBAT_BELOW_RESET,
    input wire logic VBAT_BELOW_WARN,
    output logic CORE_CLK_EN,
    output logic [PERIPHS-1:0] PERIPH_CLK_EN,
    output logic LOW_SPEED,
    output logic LFO_KEEP,
    output logic RTC_KEEP,
    output logic ASLEEP,
    output logic [RAM_BLOCKS-1:0] RAM_RETAIN,
    output logic ANALOG_EN,
    output logic [pmc_pkg::REGULATORS-1:0] REG_EN,
    output logic DRV_FROM_BUCK,
    output logic RESET_HOLD,
    output logic LOW_BATT
);
    import pmc_pkg::*;

    typedef struct packed {
        mode_t mode;
        logic slept_in_handler;
        logic [CFG_W-1:0] config_reg;
        logic [WAKE_W-1:0] wake_en;
        logic [RAM_BLOCKS-1:0] retain;
        logic [REGULATORS-1:0] reg_ctl;
        logic [PERIPHS-1:0] clk_gate;
        logic low_batt;
        logic reset_hold;
        logic core_clk;
        logic [PERIPHS-1:0] periph_clk;
        logic lfo_keep;
        logic rtc_keep;
        logic asleep;
        logic [REGULATORS-1:0] reg_en;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic halt_wake;
    logic enabled_wake;

    // Code shown in status for each mode.
    function automatic logic [ST_MODE_W-1:0] mode_code(input mode_t m);
        logic [ST_MODE_W-1:0] c;
        c = CODE_POWERUP;
        unique case (m)
            M_POWERUP: c = CODE_POWERUP;
            M_RUN: c = CODE_RUN;
            M_HALT: c = CODE_HALT;
            M_STOP: c = CODE_STOP;
            M_DEEP: c = CODE_DEEP;
            M_RESTORE: c = CODE_RESTORE;
        endcase
        return c;
    endfunction

    // Widens a narrow field to a bus word with zeros above.
    function automatic logic [DATA_W-1:0] zext(input logic [DATA_W-1:0] v,
                                               input int w);
        logic [DATA_W-1:0] mask;
        mask = {DATA_W{1'b1}} >> (DATA_W - w);
        return v & mask;
    endfunction

    wake_qualifier u_wake (
        .pin_wake(PIN_WAKE),
        .src_wake(SRC_WAKE),
        .wake_en(cur.wake_en),
        .irq_pending(IRQ_PENDING),
        .irq_takeable(IRQ_TAKEABLE),
        .slept_in_handler(cur.slept_in_handler),
        .halt_wake(halt_wake),
        .enabled_wake(enabled_wake)
    );

    // Next-state logic for the sequencer, register file and outputs.
    always_comb begin
        logic fast;
        logic [DATA_W-1:0] status;
        next_cur = cur;
        fast = cur.config_reg[CFG_FAST_WAKE];
        status = '0;

        // Register writes steer the sequencer from the next cycle on.
        if (WR) begin
            unique case (ADDR)
                OFS_CONFIG: next_cur.config_reg = WDATA[CFG_W-1:0];
                OFS_WAKE_EN: next_cur.wake_en = WDATA[WAKE_W-1:0];
                OFS_RETAIN: next_cur.retain = WDATA[RAM_BLOCKS-1:0];
                OFS_REGULATOR: next_cur.reg_ctl = WDATA[REGULATORS-1:0];
                OFS_CLOCK_GATE: next_cur.clk_gate = WDATA[PERIPHS-1:0];
                OFS_STATUS: begin
                    if (WDATA[ST_LOW_BATT]) begin
                        next_cur.low_batt = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // A low supply sets the flag after any clear, so it is never lost.
        if (VBAT_BELOW_WARN) begin
            next_cur.low_batt = 1'b1;
        end
        next_cur.reset_hold = VBAT_BELOW_RESET;

        // Mode sequencer.
        unique case (cur.mode)
            M_POWERUP: begin
                if (CORE_SUPPLY_VALID && !VBAT_BELOW_RESET) begin
                    next_cur.mode = M_RUN;
                end
            end
            M_RUN: begin
                if (SLEEP_REQ) begin
                    next_cur.slept_in_handler = IN_HANDLER;
                    if (!DEEP_SLEEP_BIT) begin
                        next_cur.mode = M_HALT;
                    end else if (cur.config_reg[CFG_MODE_SEL]) begin
                        next_cur.mode = M_DEEP;
                    end else begin
                        next_cur.mode = M_STOP;
                    end
                end
            end
            M_HALT: begin
                if (halt_wake) begin
                    next_cur.mode = M_RUN;
                end
            end
            M_STOP: begin
                if (enabled_wake) begin
                    next_cur.mode = M_RESTORE;
                end
            end
            M_DEEP: begin
                if (enabled_wake) begin
                    next_cur.mode = M_RESTORE;
                end
            end
            M_RESTORE: next_cur.mode = M_RUN;
        endcase

        // A failing battery always returns to the power-up wait.
        if (VBAT_BELOW_RESET) begin
            next_cur.mode = M_POWERUP;
        end

        // Clock gating follows the mode being entered.
        next_cur.core_clk = (next_cur.mode == M_RUN);
        unique case (next_cur.mode)
            M_RUN, M_HALT: next_cur.periph_clk = cur.clk_gate;
            // Peripherals come back one cycle before the core does.
            M_RESTORE: next_cur.periph_clk = cur.clk_gate;
            default: next_cur.periph_clk = '0;
        endcase
        next_cur.lfo_keep = (next_cur.mode == M_STOP) && fast &&
                            !cur.config_reg[CFG_FAST_SRC_RTC];
        next_cur.rtc_keep = (next_cur.mode == M_STOP) && fast &&
                            cur.config_reg[CFG_FAST_SRC_RTC];
        next_cur.asleep = (next_cur.mode == M_DEEP);
        // Regulators drop out in deepest sleep; logic runs off the battery.
        next_cur.reg_en = (next_cur.mode == M_DEEP) ? '0 :
                          cur.reg_ctl;

        // Read data stands in the cycle after the strobe only.
        status[ST_MODE_LSB +: ST_MODE_W] = mode_code(cur.mode);
        status[ST_LOW_BATT] = cur.low_batt;
        status[ST_RESET_HOLD] = cur.reset_hold;
        status[ST_SUPPLY_OK] = CORE_SUPPLY_VALID;
        next_cur.rdata = '0;
        if (RD) begin
            unique case (ADDR)
                OFS_CONFIG: next_cur.rdata = zext(DATA_W'(cur.config_reg),
                                                  CFG_W);
                OFS_WAKE_EN: next_cur.rdata = zext(DATA_W'(cur.wake_en),
                                                   WAKE_W);
                OFS_RETAIN: next_cur.rdata = zext(DATA_W'(cur.retain),
                                                  RAM_BLOCKS);
                OFS_REGULATOR: next_cur.rdata = zext(DATA_W'(cur.reg_ctl),
                                                     REGULATORS);
                OFS_CLOCK_GATE: next_cur.rdata = zext(DATA_W'(cur.clk_gate),
                                                      PERIPHS);
                OFS_STATUS: next_cur.rdata = status;
                default: next_cur.rdata = '0;
            endcase
        end
    end

    // State register; the clock enable freezes everything while low.
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            cur <= '0;
            cur.mode <= M_POWERUP;
            cur.config_reg <= CFG_RESET;
            cur.reg_ctl <= REG_RESET;
            cur.clk_gate <= '1;
            cur.reset_hold <= 1'b1;
        end else if (CE) begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state flops.
    assign RDATA = cur.rdata;
    assign CORE_CLK_EN = cur.core_clk;
    assign PERIPH_CLK_EN = cur.periph_clk;
    assign LOW_SPEED = cur.config_reg[CFG_LOW_SPEED];
    assign LFO_KEEP = cur.lfo_keep;
    assign RTC_KEEP = cur.rtc_keep;
    assign ASLEEP = cur.asleep;
    assign RAM_RETAIN = cur.retain;
    assign ANALOG_EN = cur.config_reg[CFG_ANALOG_EN];
    assign REG_EN = cur.reg_en;
    assign DRV_FROM_BUCK = cur.config_reg[CFG_DRV_BUCK];
    assign RESET_HOLD = cur.reset_hold;
    assign LOW_BATT = cur.low_batt;
endmodule // power_mode_controller

/* dv/core_model.sv */
`timescale 1ns/100ps
// Processor core, wake sources and supply monitors seen by the controller.
module core_model
    import pmc_pkg::*;
(
    input wire logic clk,
    output logic sleep_req,
    output logic deep_bit,
    output logic in_hnd,
    output logic irq_pend,
    output logic irq_take,
    output logic [pmc_pkg::WAKE_W-1:0] wake,
    output logic supply_ok,
    output logic vbat_rst,
    output logic vbat_warn
);
    // Supplies start low, as at a cold power-up.
    initial begin
        sleep_req = 1'h0;
        deep_bit = 1'h0;
        in_hnd = 1'h0;
        irq_pend = 1'h0;
        irq_take = 1'h0;
        wake = '0;
        supply_ok = 1'h0;
        vbat_rst = 1'h1;
        vbat_warn = 1'h0;
    end

    // Wake enables and slow clocks are set up by the bench before a sleep.
    // Two quiet cycles stand for the barriers, so no access is in flight.
    task automatic sleep(input logic deep, input logic hnd);
        repeat (2) @(posedge clk);
        sleep_req <= 1'h1;
        deep_bit <= deep;
        in_hnd <= hnd;
        @(posedge clk);
        sleep_req <= 1'h0;
        @(posedge clk);
    endtask
endmodule // core_model

/* dv/pmc_assertions.sv */
`timescale 1ns/100ps
// Port-level checks of the power mode controller.
module pmc_checker
    import pmc_pkg::*;
#(
    parameter int PERIPHS = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic WR,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP_BIT,
    input wire logic [pmc_pkg::PIN_WAKES-1:0] PIN_WAKE,
    input wire logic [pmc_pkg::SRC_WAKES-1:0] SRC_WAKE,
    input wire logic CORE_SUPPLY_VALID,
    input wire logic VBAT_BELOW_RESET,
    input wire logic VBAT_BELOW_WARN,
    input wire logic CORE_CLK_EN,
    input wire logic [PERIPHS-1:0] PERIPH_CLK_EN,
    input wire logic ASLEEP,
    input wire logic [pmc_pkg::REGULATORS-1:0] REG_EN,
    input wire logic RESET_HOLD,
    input wire logic LOW_BATT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // The core clock runs only in run mode, so it marks a taken request.
    a_halt_keeps_periph: assert property (
        SLEEP_REQ && CORE_CLK_EN && !DEEP_SLEEP_BIT && CE && !WR
        && !VBAT_BELOW_RESET |=> !CORE_CLK_EN && $stable(PERIPH_CLK_EN))
        else $error("halt changed clocks");
    a_stop_gates_all: assert property (
        SLEEP_REQ && CORE_CLK_EN && DEEP_SLEEP_BIT && CE
        && !VBAT_BELOW_RESET |=> !CORE_CLK_EN && PERIPH_CLK_EN == '0)
        else $error("stop left clocks on");
    a_asleep_outputs: assert property (
        ASLEEP |-> REG_EN == '0 && !CORE_CLK_EN && PERIPH_CLK_EN == '0)
        else $error("asleep with power on");
    a_deep_stays: assert property (
        ASLEEP && CE && !VBAT_BELOW_RESET && PIN_WAKE == '0
        && SRC_WAKE == '0 |=> ASLEEP)
        else $error("left deep sleep alone");
    a_restore_first: assert property (
        $fell(ASLEEP) && !$past(VBAT_BELOW_RESET) |-> !CORE_CLK_EN
        ##1 (CORE_CLK_EN || $past(VBAT_BELOW_RESET)))
        else $error("restore step missing");
    a_reset_hold: assert property (
        VBAT_BELOW_RESET && CE |=> RESET_HOLD && !CORE_CLK_EN)
        else $error("reset not held");
    a_supply_wait: assert property (
        (VBAT_BELOW_RESET && CE) ##1 (!CORE_SUPPLY_VALID && CE)
        |=> !CORE_CLK_EN)
        else $error("core ran before supply");
    a_low_batt_set: assert property (
        VBAT_BELOW_WARN && CE |=> LOW_BATT)
        else $error("low battery not flagged");
    c_deep_wake: cover property (ASLEEP ##1 !ASLEEP);
    c_halt: cover property (SLEEP_REQ && CORE_CLK_EN && !DEEP_SLEEP_BIT);
    c_low_batt: cover property ($rose(LOW_BATT));
endmodule // pmc_checker

bind power_mode_controller pmc_checker #(.PERIPHS(PERIPHS)) chk (
    .MCLK(MCLK), .NRST(NRST), .CE(CE), .WR(WR), .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_BIT(DEEP_SLEEP_BIT), .PIN_WAKE(PIN_WAKE),
    .SRC_WAKE(SRC_WAKE), .CORE_SUPPLY_VALID(CORE_SUPPLY_VALID),
    .VBAT_BELOW_RESET(VBAT_BELOW_RESET), .VBAT_BELOW_WARN(VBAT_BELOW_WARN),
    .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .ASLEEP(ASLEEP), .REG_EN(REG_EN), .RESET_HOLD(RESET_HOLD),
    .LOW_BATT(LOW_BATT));

/* dv/power_mode_controller_tb.sv */
`timescale 1ns/100ps
// Drives the controller through its register port and the core model.
module power_mode_controller_tb;
    import pmc_pkg::*;
    logic mclk, nrst, wr, rd, sreq, dbit, hnd, ipend, itake, sok, vrst;
    logic vwarn, core_en, lfo, rtc, asleep, analog, buck, hold, lowb, lsp;
    logic ce;
    logic [7:0] addr, retain;
    logic [31:0] wdata, rdata, cfg;
    logic [15:0] periph;
    logic [2:0] reg_en;
    logic [21:0] wake;
    int error_cnt = 0;
    int check_count = 0;

    core_model cm (.clk(mclk), .sleep_req(sreq), .deep_bit(dbit),
        .in_hnd(hnd), .irq_pend(ipend), .irq_take(itake), .wake(wake),
        .supply_ok(sok), .vbat_rst(vrst), .vbat_warn(vwarn));
    power_mode_controller #(.RAM_BLOCKS(8), .PERIPHS(16)) uut (
        .MCLK(mclk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SLEEP_REQ(sreq),
        .DEEP_SLEEP_BIT(dbit), .IN_HANDLER(hnd), .IRQ_PENDING(ipend),
        .IRQ_TAKEABLE(itake), .PIN_WAKE(wake[13:0]),
        .SRC_WAKE(wake[21:14]), .CORE_SUPPLY_VALID(sok),
        .VBAT_BELOW_RESET(vrst), .VBAT_BELOW_WARN(vwarn),
        .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(periph), .LOW_SPEED(lsp),
        .LFO_KEEP(lfo), .RTC_KEEP(rtc), .ASLEEP(asleep),
        .RAM_RETAIN(retain), .ANALOG_EN(analog), .REG_EN(reg_en),
        .DRV_FROM_BUCK(buck), .RESET_HOLD(hold), .LOW_BATT(lowb));

    // A 5 ns clock.
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Writes take effect a cycle later, so callers let two edges pass.
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1 chk(rdata, exp);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // The sequence needs about 415 cycles; this allows over twenty times more.
    initial begin
        #50000;
        error_cnt++;
        stop_test();
    end

    initial begin
        nrst = 1'h0; wr = 1'h0; rd = 1'h0; addr = '0; wdata = '0;
        ce = 1'h1;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        #1 chk({analog, hold, core_en}, 32'h6);
        rreg(OFS_CONFIG, {26'h0, CFG_RESET});
        rreg(OFS_REGULATOR, 32'h7);
        rreg(8'hFC, 32'h0);
        @(posedge mclk);
        cm.vbat_rst <= 1'h0;
        repeat (4) @(posedge mclk);
        #1 chk({hold, core_en}, 32'h0);
        @(posedge mclk);
        cm.supply_ok <= 1'h1;
        repeat (3) @(posedge mclk);
        rreg(OFS_STATUS, 32'h21);
        wreg(OFS_REGULATOR, 32'h5);
        wreg(OFS_RETAIN, 32'hA5);
        wreg(OFS_CLOCK_GATE, 32'h5A3C);
        wreg(OFS_CONFIG, 32'h12);
        repeat (2) @(posedge mclk);
        #1 chk({reg_en, retain}, 32'h5A5);
        chk({buck, lsp, analog, periph}, 32'h65A3C);
        // Halt, woken by any pending interrupt, then from a handler.
        cm.sleep(1'h0, 1'h0);
        #1 chk({core_en, lsp, periph}, 32'h15A3C);
        rreg(OFS_STATUS, 32'h22);
        @(posedge mclk);
        cm.irq_pend <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk(core_en, 32'h1);
        cm.sleep(1'h0, 1'h1);
        repeat (3) @(posedge mclk);
        #1 chk(core_en, 32'h0);
        @(posedge mclk);
        cm.irq_take <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk(core_en, 32'h1);
        @(posedge mclk);
        cm.irq_pend <= 1'h0;
        cm.irq_take <= 1'h0;
        // Every wake source, alternating clock stop and deepest sleep.
        // Fast wake is on; its source alternates between slow clocks.
        for (int i = 0; i < 22; i++) begin
            cfg = {26'h0, 2'h1, i[1], 2'h3, i[0]};
            wreg(OFS_CONFIG, cfg);
            wreg(OFS_WAKE_EN, 32'h1 << i);
            cm.sleep(1'h1, 1'h0);
            #1 chk({core_en, asleep, periph}, {i[0], 16'h0});
            if (!i[0])
                chk({rtc, lfo}, {i[1], !i[1]});
            @(posedge mclk);
            cm.wake <= 22'h1 << ((i + 1) % 22);
            cm.irq_pend <= 1'h1;
            repeat (3) @(posedge mclk);
            #1 chk({core_en, asleep}, {i[0]});
            @(posedge mclk);
            cm.wake <= 22'h1 << i;
            cm.irq_pend <= 1'h0;
            @(posedge mclk);
            #1 chk({core_en, periph}, 32'h5A3C);
            @(posedge mclk);
            #1 chk(core_en, 32'h1);
            @(posedge mclk);
            cm.wake <= '0;
        end
        // A low clock enable must hold the warning flag back.
        @(posedge mclk);
        ce <= 1'h0;
        cm.vbat_warn <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk(lowb, 32'h0);
        @(posedge mclk);
        ce <= 1'h1;
        cm.vbat_warn <= 1'h1;
        @(posedge mclk);
        cm.vbat_warn <= 1'h0;
        rreg(OFS_STATUS, 32'h29);
        wreg(OFS_STATUS, 32'h8);
        repeat (2) @(posedge mclk);
        #1 chk(lowb, 32'h0);
        @(posedge mclk);
        cm.vbat_rst <= 1'h1;
        repeat (2) @(posedge mclk);
        #1 chk({hold, core_en}, 32'h2);
        stop_test();
    end
endmodule // power_mode_controller_tb
